// file: rtl/scc_pkg.sv
package scc_pkg;
  localparam logic [7:0] ADDR_RUN_CFG = 8'h00;
  localparam logic [7:0] ADDR_RUN_EXT = 8'h04;
  localparam logic [7:0] ADDR_OSC_CTL = 8'h08;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h0c;
  localparam logic [7:0] ADDR_REG_CTL = 8'h10;
  localparam logic [7:0] ADDR_PLL_XLATE = 8'h14;
  localparam logic [7:0] ADDR_PERIPH_GATE = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam int CFG_MAIN_DIS = 0;
  localparam int CFG_INT_DIS = 1;
  localparam int CFG_SRC_LSB = 4;
  localparam int CFG_CRYSTAL_NUMBER_LSB = 6;
  localparam int CFG_BYPASS = 11;
  localparam int CFG_PWRDN = 13;
  localparam int CFG_USESYS = 22;
  localparam int CFG_DIV_LSB = 23;
  localparam int EXT_USB_PD = 14;
  localparam int EXT_USE = 31;
  localparam int OSC_CHECK_BIT = 0;
  localparam int RC_POR_BIT = 0;
  localparam int RC_FAIL_BIT = 16;
  localparam logic [31:0] RUN_CFG_RST = 32'h0000_2ad1;
  localparam logic [31:0] RUN_EXT_RST = 32'h0000_6810;
  localparam logic [3:0] VOLTAGE_ADJUST_RST = 4'h5;
  localparam logic [7:0] PERIPH_GATE_RST = 8'h00;
  localparam logic [4:0] CRYSTAL_NUMBER_Q_RST = 5'h1f;
  localparam logic [15:0] RELOCK_LOAD = 16'h1200;
  localparam logic [15:0] RELOCK_LOAD_HI = 16'h2400;
  localparam logic [4:0] CRYSTAL_NUMBER_HI_LIMIT = 5'h0f;
  localparam logic [5:0] FAIL_HOLD_TICKS = 6'd32;
  localparam logic [7:0] CHK_WINDOW = 8'd64;
  localparam logic [7:0] CHK_MIN = 8'd3;
  localparam logic [7:0] CHK_MAX = 8'd125;
  localparam logic [3:0] VOLTAGE_ADJUST_MAX = 4'd10;
  localparam logic [11:0] VOUT_MIN_MV = 12'd2250;
  localparam logic [11:0] VOUT_MAX_MV = 12'd2750;
  localparam logic [11:0] REGULATOR_STEP_MV = 12'd50;
  localparam int PLL_VCO_MHZ = 400;
  localparam int ADC_MHZ = 16;
  localparam logic [4:0] ADC_DIV = 5'(PLL_VCO_MHZ / ADC_MHZ);

  typedef enum logic [2:0] {
    SRC_MAIN = 3'h0, SRC_INT = 3'h1, SRC_INT4 = 3'h2,
    SRC_LF = 3'h3, SRC_RTC = 3'h4, SRC_PLL = 3'h5
  } scc_src_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001, ST_HOLD = 3'b010, ST_NMI = 3'b100
  } scc_state_t;

  typedef struct packed {
    logic int_fast;
    logic main;
    logic low_freq;
    logic rtc;
    logic pll;
  } scc_ticks_t;

  typedef struct packed {
    logic [4:0] r;
    logic [13:0] f;
  } scc_pll_set_t;

  // VCO target is PLL_VCO_MHZ; every pair lands within 0.02 percent
  function automatic scc_pll_set_t scc_xlate(input logic [4:0] x);
    scc_pll_set_t s;
    s = '0;
    case (x)
      5'h04: s = '{r: 5'd4, f: 14'd447};
      5'h0a: s = '{r: 5'd1, f: 14'd100};
      5'h0b: s = '{r: 5'd1, f: 14'd80};
      5'h0c: s = '{r: 5'd3, f: 14'd200};
      5'h0e: s = '{r: 5'd1, f: 14'd50};
      5'h10: s = '{r: 5'd1, f: 14'd40};
      5'h12: s = '{r: 5'd3, f: 14'd100};
      5'h14: s = '{r: 5'd1, f: 14'd25};
      5'h15: s = '{r: 5'd12, f: 14'd293};
      default: s = '0;
    endcase
    return s;
  endfunction
endpackage

// file: rtl/scc_relock.sv
`timescale 1ns/10ps
module scc_relock
  import scc_pkg::*;
(
  input logic clk_sys,
  input logic sys_rst,
  input logic main_crystal_osc_tick,
  input logic restart,
  input logic hi_crystal,
  output logic ready
);
  logic [15:0] count;
  logic [15:0] next_count;

  // Counts only on main oscillator ticks: a dead crystal never reports lock
  always_comb
  begin
    next_count = count;
    if (restart)
      next_count = hi_crystal ? RELOCK_LOAD_HI : RELOCK_LOAD;
    else if (main_crystal_osc_tick && count != 16'h0)
      next_count = count - 16'h1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      count <= RELOCK_LOAD;
    else
      count <= next_count;
  end

  assign ready = (count == 16'h0);

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_relock_load: assert property (
    restart |=> count == ($past(hi_crystal) ? RELOCK_LOAD_HI : RELOCK_LOAD))
    else $error("relock count loaded wrong value");
  a_relock_hold: assert property (
    !restart && !main_crystal_osc_tick |=> $stable(count))
    else $error("relock count moved without oscillator tick");
endmodule

// file: rtl/scc_clock_ctrl.sv
`timescale 1ns/10ps
module scc_clock_ctrl
  import scc_pkg::*;
(
  input logic clk_sys,
  input logic sys_rst,
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  input scc_ticks_t osc_ticks,
  input logic nmi_pin,
  input logic nmi_pin_en,
  output logic system_clock_out,
  output logic [7:0] periph_clk_en,
  output logic adc_clk_en,
  output logic main_osc_en,
  output logic int_osc_en,
  output logic main_pll_normal,
  output scc_pll_set_t main_pll_cfg,
  output logic usb_pll_normal,
  output logic usb_pll_ready,
  output logic sys_reset_req,
  output logic nmi_req,
  output logic [11:0] regulator_mv
);
  scc_state_t state, next_state;
  logic [31:0] run_cfg, next_run_cfg, run_ext, next_run_ext;
  logic osc_check, next_osc_check;
  logic rc_por, next_rc_por, rc_fail, next_rc_fail;
  logic [3:0] voltage_adjust, next_voltage_adjust;
  logic [7:0] gate, next_gate;
  logic [4:0] crystal_number_q;
  logic main_pd_q, usb_pd_q;
  scc_pll_set_t pll_xlate, next_pll_xlate;
  logic [7:0] chk_win, next_chk_win, chk_cnt, next_chk_cnt;
  logic [5:0] hold_cnt, next_hold_cnt;
  logic fail_det, next_nmi;
  scc_src_t cur_src, next_cur_src, want_src;
  logic [1:0] int4_cnt, next_int4_cnt;
  logic [5:0] div_cnt, next_div_cnt;
  logic [4:0] adc_cnt, next_adc_cnt;
  logic int4_tick, src_tick, sys_pulse, adc_pulse;
  logic next_system_clock_out, next_adc;
  logic [7:0] next_periph;
  logic [31:0] next_rdata;
  logic use_ext, eff_bypass, eff_pwrdn, usb_pd, hi_crystal_number, pll_ready, main_ready;
  logic crystal_number_chg, main_restart, usb_restart;
  logic [2:0] eff_src;
  logic [5:0] eff_div;
  logic [4:0] crystal;

  function automatic logic scc_tick_of(input scc_src_t s, input scc_ticks_t t,
                                       input logic i4);
    case (s)
      SRC_MAIN: return t.main;
      SRC_INT: return t.int_fast;
      SRC_INT4: return i4;
      SRC_LF: return t.low_freq;
      SRC_RTC: return t.rtc;
      SRC_PLL: return t.pll;
      default: return 1'b0;
    endcase
  endfunction

  // Extended register overrides the shared fields when selected
  assign use_ext = run_ext[EXT_USE];
  assign eff_src = use_ext ? run_ext[CFG_SRC_LSB +: 3]
                           : {1'b0, run_cfg[CFG_SRC_LSB +: 2]};
  assign eff_bypass = use_ext ? run_ext[CFG_BYPASS] : run_cfg[CFG_BYPASS];
  assign eff_pwrdn = use_ext ? run_ext[CFG_PWRDN] : run_cfg[CFG_PWRDN];
  assign eff_div = use_ext ? run_ext[CFG_DIV_LSB +: 6]
                           : {2'b00, run_cfg[CFG_DIV_LSB +: 4]};
  assign usb_pd = run_ext[EXT_USB_PD];
  assign crystal = run_cfg[CFG_CRYSTAL_NUMBER_LSB +: 5];
  assign hi_crystal_number = crystal > CRYSTAL_NUMBER_HI_LIMIT;
  assign crystal_number_chg = crystal != crystal_number_q;
  assign main_restart = crystal_number_chg | (main_pd_q & ~eff_pwrdn);
  assign usb_restart = crystal_number_chg | (usb_pd_q & ~usb_pd);
  assign pll_ready = main_ready & ~eff_pwrdn;

  scc_relock u_relock_main (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .main_crystal_osc_tick(osc_ticks.main),
    .restart(main_restart),
    .hi_crystal(hi_crystal_number),
    .ready(main_ready)
  );

  // USB PLL takes only the main oscillator as reference and is unguarded
  scc_relock u_relock_usb (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .main_crystal_osc_tick(osc_ticks.main),
    .restart(usb_restart),
    .hi_crystal(hi_crystal_number),
    .ready(usb_pll_ready)
  );

  // Registers; a failure reset returns configuration to defaults
  always_comb
  begin
    next_run_cfg = run_cfg;
    next_run_ext = run_ext;
    next_osc_check = osc_check;
    next_rc_por = rc_por;
    next_rc_fail = rc_fail;
    next_voltage_adjust = voltage_adjust;
    next_gate = gate;
    if (state != ST_RUN)
    begin
      next_run_cfg = RUN_CFG_RST;
      next_run_ext = RUN_EXT_RST;
      next_osc_check = 1'b0;
      next_voltage_adjust = VOLTAGE_ADJUST_RST;
      next_gate = PERIPH_GATE_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_RUN_CFG: next_run_cfg = reg_wdata;
        ADDR_RUN_EXT: next_run_ext = reg_wdata;
        ADDR_OSC_CTL: next_osc_check = reg_wdata[OSC_CHECK_BIT];
        ADDR_RESET_CAUSE:
        begin
          next_rc_por = rc_por & reg_wdata[RC_POR_BIT];
          next_rc_fail = rc_fail & reg_wdata[RC_FAIL_BIT];
        end
        ADDR_REG_CTL: next_voltage_adjust = (reg_wdata[3:0] > VOLTAGE_ADJUST_MAX) ? VOLTAGE_ADJUST_MAX : reg_wdata[3:0];
        ADDR_PERIPH_GATE: next_gate = reg_wdata[7:0];
        default: ;
      endcase
    end
    // Set wins over a clear written in the same cycle
    if (fail_det)
      next_rc_fail = 1'b1;
    next_pll_xlate = crystal_number_chg ? scc_xlate(crystal) : pll_xlate;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_cfg <= RUN_CFG_RST;
      run_ext <= RUN_EXT_RST;
      osc_check <= 1'b0;
      rc_por <= 1'b1;
      rc_fail <= 1'b0;
      voltage_adjust <= VOLTAGE_ADJUST_RST;
      gate <= PERIPH_GATE_RST;
      crystal_number_q <= CRYSTAL_NUMBER_Q_RST;
      main_pd_q <= 1'b1;
      usb_pd_q <= 1'b1;
      pll_xlate <= '0;
    end
    else
    begin
      run_cfg <= next_run_cfg;
      run_ext <= next_run_ext;
      osc_check <= next_osc_check;
      rc_por <= next_rc_por;
      rc_fail <= next_rc_fail;
      voltage_adjust <= next_voltage_adjust;
      gate <= next_gate;
      crystal_number_q <= crystal;
      main_pd_q <= eff_pwrdn;
      usb_pd_q <= usb_pd;
      pll_xlate <= next_pll_xlate;
    end
  end

  // Oscillator check window and failure sequence
  always_comb
  begin
    next_chk_win = chk_win;
    next_chk_cnt = chk_cnt;
    next_state = state;
    next_hold_cnt = hold_cnt;
    fail_det = 1'b0;
    next_nmi = nmi_pin_en & nmi_pin;
    if (!osc_check || state != ST_RUN)
    begin
      next_chk_win = 8'h00;
      next_chk_cnt = 8'h00;
    end
    else
    begin
      if (osc_ticks.main && chk_cnt != 8'hff)
        next_chk_cnt = chk_cnt + 8'd1;
      if (osc_ticks.int_fast)
      begin
        if (chk_win == CHK_WINDOW - 8'd1)
        begin
          fail_det = (chk_cnt < CHK_MIN) || (chk_cnt > CHK_MAX);
          next_chk_win = 8'h00;
          next_chk_cnt = 8'h00;
        end
        else
          next_chk_win = chk_win + 8'd1;
      end
    end
    unique case (state)
      ST_RUN:
        if (fail_det)
        begin
          next_state = ST_HOLD;
          next_hold_cnt = 6'd0;
        end
      ST_HOLD:
        if (osc_ticks.int_fast)
        begin
          if (hold_cnt == FAIL_HOLD_TICKS - 6'd1)
          begin
            next_state = ST_NMI;
            next_nmi = 1'b1;
          end
          else
            next_hold_cnt = hold_cnt + 6'd1;
        end
      ST_NMI: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ST_RUN;
      chk_win <= 8'h00;
      chk_cnt <= 8'h00;
      hold_cnt <= 6'd0;
      nmi_req <= 1'b0;
    end
    else
    begin
      state <= next_state;
      chk_win <= next_chk_win;
      chk_cnt <= next_chk_cnt;
      hold_cnt <= next_hold_cnt;
      nmi_req <= next_nmi;
    end
  end

  // Source mux: a change lands only on a tick of the old source, unless the
  // old source is the PLL and it has lost ready, so no shortened pulse; a
  // failure forces the internal source at once since the old one may be dead
  always_comb
  begin
    int4_tick = osc_ticks.int_fast && int4_cnt == 2'd3;
    next_int4_cnt = osc_ticks.int_fast ? int4_cnt + 2'd1 : int4_cnt;
    src_tick = scc_tick_of(cur_src, osc_ticks, int4_tick);
    if (state != ST_RUN)
      want_src = SRC_INT;
    else if (!eff_bypass && !eff_pwrdn && run_cfg[CFG_USESYS] && pll_ready)
      want_src = SRC_PLL;
    else if (eff_src <= 3'h4)
      want_src = scc_src_t'(eff_src);
    else
      want_src = SRC_INT;
    next_cur_src = cur_src;
    if (state != ST_RUN || (cur_src == SRC_PLL && !pll_ready))
      next_cur_src = want_src;
    else if (want_src != cur_src && src_tick)
      next_cur_src = want_src;
    sys_pulse = 1'b0;
    next_div_cnt = div_cnt;
    if (src_tick)
    begin
      if (!run_cfg[CFG_USESYS] || div_cnt >= eff_div)
      begin
        sys_pulse = 1'b1;
        next_div_cnt = 6'd0;
      end
      else
        next_div_cnt = div_cnt + 6'd1;
    end
    adc_pulse = 1'b0;
    next_adc_cnt = adc_cnt;
    if (osc_ticks.pll && pll_ready)
    begin
      if (adc_cnt == ADC_DIV - 5'd1)
      begin
        adc_pulse = 1'b1;
        next_adc_cnt = 5'd0;
      end
      else
        next_adc_cnt = adc_cnt + 5'd1;
    end
    next_system_clock_out = sys_pulse;
    next_periph = gate & {8{sys_pulse}};
    next_adc = adc_pulse & gate[0];
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur_src <= SRC_INT;
      int4_cnt <= 2'd0;
      div_cnt <= 6'd0;
      adc_cnt <= 5'd0;
      system_clock_out <= 1'b0;
      periph_clk_en <= 8'h00;
      adc_clk_en <= 1'b0;
    end
    else
    begin
      cur_src <= next_cur_src;
      int4_cnt <= next_int4_cnt;
      div_cnt <= next_div_cnt;
      adc_cnt <= next_adc_cnt;
      system_clock_out <= next_system_clock_out;
      periph_clk_en <= next_periph;
      adc_clk_en <= next_adc;
    end
  end

  always_comb
  begin
    next_rdata = 32'h0;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_RUN_CFG: next_rdata = run_cfg;
        ADDR_RUN_EXT: next_rdata = run_ext;
        ADDR_OSC_CTL: next_rdata[OSC_CHECK_BIT] = osc_check;
        ADDR_RESET_CAUSE:
        begin
          next_rdata[RC_POR_BIT] = rc_por;
          next_rdata[RC_FAIL_BIT] = rc_fail;
        end
        ADDR_REG_CTL: next_rdata = {28'h0, voltage_adjust};
        ADDR_PLL_XLATE: next_rdata = {13'h0, pll_xlate};
        ADDR_PERIPH_GATE: next_rdata = {24'h0, gate};
        ADDR_STATUS: next_rdata = {27'h0, usb_pll_ready, pll_ready, cur_src};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= next_rdata;
  end

  assign sys_reset_req = (state == ST_HOLD);
  assign int_osc_en = ~run_cfg[CFG_INT_DIS] | (state != ST_RUN);
  assign main_osc_en = ~run_cfg[CFG_MAIN_DIS];
  assign main_pll_normal = ~eff_pwrdn;
  assign main_pll_cfg = pll_xlate;
  assign usb_pll_normal = ~usb_pd;
  assign regulator_mv = 12'(VOUT_MIN_MV + REGULATOR_STEP_MV * {8'h0, voltage_adjust});

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence seq_fail_enter;
    state == ST_RUN ##1 state == ST_HOLD;
  endsequence

  a_fail_gated: assert property (seq_fail_enter |-> $past(osc_check))
    else $error("oscillator failure taken while checking disabled");
  a_fail_flag: assert property (seq_fail_enter |-> rc_fail && sys_reset_req)
    else $error("failure did not set flag and reset");
  a_hold_int: assert property (
    state == ST_HOLD |=> int_osc_en && cur_src == SRC_INT)
    else $error("internal oscillator not forced during failure reset");
  a_nmi_release: assert property ($fell(sys_reset_req) |-> nmi_req)
    else $error("no interrupt at failure reset release");
  a_nmi_pin: assert property (nmi_pin_en && nmi_pin |=> nmi_req)
    else $error("enabled interrupt pin not followed");
  a_pll_locked: assert property (
    cur_src == SRC_PLL && $past(cur_src) != SRC_PLL |-> $past(pll_ready))
    else $error("PLL taken before relock ended");
  a_xlate_upd: assert property (
    crystal_number_chg |=> pll_xlate == scc_xlate($past(crystal)))
    else $error("translation not updated on crystal change");
  a_switch_clean: assert property (
    state == ST_RUN && $past(state) == ST_RUN && $changed(cur_src)
      && $past(cur_src) != SRC_PLL |-> $past(src_tick))
    else $error("clock source switched mid period");
  a_vout_range: assert property (
    regulator_mv >= VOUT_MIN_MV && regulator_mv <= VOUT_MAX_MV)
    else $error("regulator target outside range");
endmodule

// file: bench/scc_osc_model.sv
`timescale 1ns/10ps
module scc_osc_model
  import scc_pkg::*;
(
  input logic clk_sys,
  input logic main_osc_en,
  input logic int_osc_en,
  input logic main_pll_normal,
  input logic main_dead,
  output scc_ticks_t osc_ticks
);
  logic [7:0] phase = 8'h00;

  always @(posedge clk_sys)
  begin
    phase <= phase + 8'h01;
    osc_ticks.int_fast <= int_osc_en & ~phase[0];
    // Crystal at half rate keeps the check count mid-band
    osc_ticks.main <= main_osc_en & ~main_dead & phase[0];
    osc_ticks.low_freq <= (phase % 8'd5) == 8'd0;
    osc_ticks.rtc <= (phase % 8'd7) == 8'd3;
    // A powered-down PLL leaves its output silent
    osc_ticks.pll <= main_pll_normal;
  end
endmodule

// file: bench/test_scc_clock_ctrl.sv
`timescale 1ns/10ps
module test_scc_clock_ctrl
  import scc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic nmi_pin = 1'b0;
  logic nmi_pin_en = 1'b0;
  logic main_dead = 1'b0;
  logic [31:0] reg_rdata;
  scc_ticks_t osc_ticks;
  scc_pll_set_t main_pll_cfg;
  logic system_clock_out, adc_clk_en, main_osc_en, int_osc_en, main_pll_normal;
  logic usb_pll_normal, usb_pll_ready, sys_reset_req, nmi_req;
  logic [7:0] periph_clk_en;
  logic [11:0] regulator_mv;
  int error_cnt = 0;
  int checks_done = 0;
  int cycle_cnt = 0;
  int n;
  int v;
  logic [31:0] rd;
  logic [31:0] cfg;
  logic [3:0] code;
  logic [7:0] gate;
  logic [4:0] xc [10] = '{5'h04, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h10, 5'h12, 5'h14, 5'h15, 5'h05};

  always #20 clk_sys = ~clk_sys;

  scc_clock_ctrl i_scc_clock_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_ticks(osc_ticks), .nmi_pin(nmi_pin), .nmi_pin_en(nmi_pin_en),
    .system_clock_out(system_clock_out), .periph_clk_en(periph_clk_en),
    .adc_clk_en(adc_clk_en), .main_osc_en(main_osc_en), .int_osc_en(int_osc_en),
    .main_pll_normal(main_pll_normal), .main_pll_cfg(main_pll_cfg),
    .usb_pll_normal(usb_pll_normal), .usb_pll_ready(usb_pll_ready),
    .sys_reset_req(sys_reset_req), .nmi_req(nmi_req), .regulator_mv(regulator_mv));

  scc_osc_model i_scc_osc_model (.clk_sys(clk_sys), .main_osc_en(main_osc_en),
    .int_osc_en(int_osc_en), .main_pll_normal(main_pll_normal), .main_dead(main_dead),
    .osc_ticks(osc_ticks));

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic count_hi(ref logic s, input int k, output int c);
    c = 0;
    repeat (k)
    begin
      @(posedge clk_sys);
      if (s === 1'b1)
        c++;
    end
  endtask

  // Counts crystal edges, since relock is timed on the crystal, not on clk_sys
  task automatic wait_main(input int k);
    n = 0;
    while (n < k)
    begin
      @(posedge clk_sys);
      if (osc_ticks.main === 1'b1)
        n++;
    end
  endtask

  function automatic real xmhz(input logic [4:0] x);
    case (x)
      5'h04: return 3.579545;
      5'h0a: return 4.0;
      5'h0b: return 5.0;
      5'h0c: return 6.0;
      5'h0e: return 8.0;
      5'h10: return 10.0;
      5'h12: return 12.0;
      5'h14: return 16.0;
      5'h15: return 16.384;
      default: return 0.0;
    endcase
  endfunction

  function automatic logic in_band(input real mhz, input logic [4:0] r, input logic [13:0] f);
    real vco;
    if (mhz == 0.0)
      return (r === 5'h0) && (f === 14'h0);
    if (r === 5'h0 || $isunknown({r, f}))
      return 1'b0;
    vco = mhz * f / r;
    return (vco >= PLL_VCO_MHZ * 0.99) && (vco <= PLL_VCO_MHZ * 1.01);
  endfunction

  always @(posedge clk_sys)
  begin
    cycle_cnt++;
    if (cycle_cnt == 50000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial
  begin
    void'($urandom(32'h4b63));
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    check("int_osc_en", 1, int_osc_en);
    check("pll_normal", 0, {usb_pll_normal, main_pll_normal});
    check("main_osc_en", 0, main_osc_en);
    rdr(ADDR_RUN_CFG, rd);
    check("run_cfg", RUN_CFG_RST, rd);
    rdr(ADDR_RUN_EXT, rd);
    check("run_ext", RUN_EXT_RST, rd);
    rdr(ADDR_STATUS, rd);
    check("status", 32'h1, rd);
    rdr(8'h20, rd);
    check("unmapped", 0, rd);
    count_hi(system_clock_out, 20, n);
    check("sys_pulses", 10, n);
    for (int i = 0; i < 8; i++)
    begin
      code = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : (i == 2) ? 4'ha : 4'($urandom_range(15, 0));
      v = (code > 4'ha) ? 10 : int'(code);
      wr(ADDR_REG_CTL, {28'h0, code});
      rdr(ADDR_REG_CTL, rd);
      check("voltage_adjust", 32'(v), rd);
      check("regulator_mv", 32'(2250 + 50 * v), {20'h0, regulator_mv});
    end
    gate = 8'($urandom()) | 8'h01;
    wr(ADDR_PERIPH_GATE, {24'h0, gate});
    // Gate lands one edge before the pulses that use it
    cyc(1);
    repeat (12)
    begin
      @(posedge clk_sys);
      check("periph_clk_en", system_clock_out ? gate : 8'h00, periph_clk_en);
    end
    nmi_pin_en <= 1'b1;
    nmi_pin <= 1'b1;
    cyc(2);
    check("nmi_req", 1, nmi_req);
    nmi_pin <= 1'b0;
    cyc(2);
    check("nmi_req", 0, nmi_req);
    nmi_pin_en <= 1'b0;
    nmi_pin <= 1'b1;
    cyc(2);
    check("nmi_req", 0, nmi_req);
    nmi_pin <= 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_RUN_CFG, (RUN_CFG_RST & ~32'h31) | (32'(s) << CFG_SRC_LSB));
      cyc(40);
      rdr(ADDR_STATUS, rd);
      check("source", 32'(s), {29'h0, rd[2:0]});
      check("main_osc_en", 1, main_osc_en);
    end
    for (int s = 4; s < 7; s++)
    begin
      wr(ADDR_RUN_EXT, {1'b1, RUN_EXT_RST[30:15], 1'b0, RUN_EXT_RST[13:7], 3'(s), 4'h0});
      cyc(40);
      rdr(ADDR_STATUS, rd);
      check("ext_source", (s > 4) ? 32'h1 : 32'(s), {29'h0, rd[2:0]});
      check("usb_pll_normal", 1, usb_pll_normal);
    end
    wr(ADDR_RUN_EXT, RUN_EXT_RST);
    cyc(1);
    foreach (xc[i])
    begin
      wr(ADDR_RUN_CFG, (RUN_CFG_RST & ~(32'h1f << CFG_CRYSTAL_NUMBER_LSB)) | (32'(xc[i]) << CFG_CRYSTAL_NUMBER_LSB));
      // Translation follows the crystal field one edge later
      cyc(1);
      rdr(ADDR_PLL_XLATE, rd);
      check("xlate_band", 1, in_band(xmhz(xc[i]), rd[18:14], rd[13:0]));
      check("pll_cfg_band", 1, in_band(xmhz(xc[i]), main_pll_cfg.r, main_pll_cfg.f));
    end
    cfg = (32'h1 << CFG_USESYS) | (32'h0e << CFG_CRYSTAL_NUMBER_LSB);
    wr(ADDR_RUN_CFG, cfg);
    cyc(1);
    check("main_pll_normal", 1, main_pll_normal);
    wait_main(32'h1200 - 8);
    rdr(ADDR_STATUS, rd);
    check("pll_early", 32'h0, {28'h0, rd[3:0]});
    wait_main(16);
    rdr(ADDR_STATUS, rd);
    check("pll_taken", 32'hd, {28'h0, rd[3:0]});
    count_hi(adc_clk_en, 50, n);
    check("adc_pulses", 2, n);
    wr(ADDR_RUN_CFG, cfg);
    rdr(ADDR_STATUS, rd);
    check("same_crystal_number", 1, rd[3]);
    wr(ADDR_RUN_CFG, (32'h1 << CFG_USESYS) | (32'h10 << CFG_CRYSTAL_NUMBER_LSB));
    wait_main(32'h2400 - 8);
    rdr(ADDR_STATUS, rd);
    check("hi_relock", 32'h0, {28'h0, rd[3:0]});
    check("usb_pll_ready", 0, usb_pll_ready);
    wait_main(16);
    rdr(ADDR_STATUS, rd);
    check("hi_ready", 1, rd[3]);
    check("usb_pll_ready", 1, usb_pll_ready);
    // Run from a healthy crystal with checking on, then kill it
    wr(ADDR_RUN_CFG, RUN_CFG_RST & ~32'h31);
    cyc(1);
    wr(ADDR_OSC_CTL, 32'h1);
    cyc(300);
    check("no_fail", 0, sys_reset_req);
    main_dead <= 1'b1;
    n = 0;
    while (sys_reset_req !== 1'b1 && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("fail_reset", 1, sys_reset_req);
    check("fail_int_osc", 1, int_osc_en);
    rdr(ADDR_STATUS, rd);
    check("fail_source", 1, {29'h0, rd[2:0]});
    n = 2;
    while (nmi_req !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("fail_nmi", 1, nmi_req);
    check("fail_release", 0, sys_reset_req);
    check("hold_len", 1, n >= 60 && n <= 66);
    rdr(ADDR_RESET_CAUSE, rd);
    check("osc_fail_flag", 1, rd[RC_FAIL_BIT]);
    rdr(ADDR_RUN_CFG, rd);
    check("cfg_restored", RUN_CFG_RST, rd);
    rdr(ADDR_OSC_CTL, rd);
    check("check_off", 0, rd);
    cyc(300);
    check("no_refail", 0, sys_reset_req);
    tally_and_finish();
  end
endmodule
